// ===== design/pbe_engine.sv
// PRBS packet generator, checker and Avalon-MM register slave
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
module pbe_engine
  import pbe_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [pbe_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic TX_EN,
  output logic [3:0] TX_NIB,
  input wire logic RX_DV,
  input wire logic [3:0] RX_NIB,
  output logic IRQ
);
  import pbe_pkg::*;

  function automatic logic [7:0] prbs_next(input logic [7:0] s);
    prbs_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Bus slave: one wait cycle, then the access completes
  logic ack;
  logic [7:0] idx;
  logic wr_go;
  assign idx = AVS_ADDRESS[ADDR_W-1:2];
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
  assign wr_go = AVS_WRITE & ack;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack <= 1'b0;
    end else begin
      ack <= (AVS_READ | AVS_WRITE) & ~ack;
    end
  end

  logic sat_mode;
  logic gen_en;
  logic [15:0] pkt_len;
  logic [7:0] gap_len;
  logic [EV_W-1:0] irq_en;
  logic lock_pulse;
  logic clr_pulse;
  logic wr_lo;
  assign wr_lo = wr_go & AVS_BYTEENABLE[0];
  assign lock_pulse = wr_lo & (idx == IDX_STS_LOCK) &
    (AVS_WRITEDATA[BIT_LOCK] | AVS_WRITEDATA[BIT_LOCK_CLR]);
  assign clr_pulse = wr_lo & (idx == IDX_STS_LOCK) &
    AVS_WRITEDATA[BIT_LOCK_CLR];

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sat_mode <= 1'b0;
      gen_en <= 1'b0;
      pkt_len <= RST_PKT_LEN;
      gap_len <= RST_GAP;
      irq_en <= '0;
    end else if (wr_go) begin
      if (idx == IDX_CFG && AVS_BYTEENABLE[0]) begin
        sat_mode <= AVS_WRITEDATA[BIT_SAT_MODE];
        gen_en <= AVS_WRITEDATA[BIT_GEN_EN];
      end
      if (idx == IDX_PKT_LEN) begin
        if (AVS_BYTEENABLE[0]) begin
          pkt_len[7:0] <= AVS_WRITEDATA[7:0];
        end
        if (AVS_BYTEENABLE[1]) begin
          pkt_len[15:8] <= AVS_WRITEDATA[15:8];
        end
      end
      if (idx == IDX_GAP && AVS_BYTEENABLE[0]) begin
        gap_len <= AVS_WRITEDATA[7:0];
      end
      if (idx == IDX_IRQ_EN && AVS_BYTEENABLE[0]) begin
        irq_en <= AVS_WRITEDATA[EV_W-1:0];
      end
    end
  end

  // Generator: nibble stream, payload bytes low nibble first
  pbe_gen_t gen_state;
  logic [16:0] gcnt;
  logic [7:0] gen_prbs;
  logic pkt_sent;
  logic [16:0] data_last;
  logic [16:0] gap_last;
  assign data_last = {pkt_len, 1'b0} - 17'd1;
  // Eight idle nibble cycles per field step, four bytes each
  assign gap_last = (17'(gap_len) << GAP_NIB_SHIFT) - 17'd1;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      gen_state <= G_IDLE;
      gcnt <= '0;
      gen_prbs <= PRBS_SEED;
      pkt_sent <= 1'b0;
      TX_EN <= 1'b0;
      TX_NIB <= '0;
    end else begin
      pkt_sent <= 1'b0;
      TX_EN <= 1'b0;
      TX_NIB <= '0;
      gcnt <= gcnt + 17'd1;
      unique case (gen_state)
        G_IDLE: begin
          gcnt <= '0;
          if (gen_en) begin
            gen_state <= G_PRE;
          end
        end
        G_PRE: begin
          TX_EN <= 1'b1;
          TX_NIB <= NIB_PRE;
          if (gcnt == PRE_NIBS - 17'd1) begin
            gen_state <= G_SFD;
            gcnt <= '0;
          end
        end
        G_SFD: begin
          TX_EN <= 1'b1;
          TX_NIB <= gcnt[0] ? SFD[7:4] : SFD[3:0];
          gen_prbs <= PRBS_SEED;
          if (gcnt[0]) begin
            gcnt <= '0;
            gen_state <= (pkt_len == 16'h0000) ? G_GAP : G_DATA;
          end
        end
        G_DATA: begin
          TX_EN <= 1'b1;
          TX_NIB <= gcnt[0] ? gen_prbs[7:4] : gen_prbs[3:0];
          if (gcnt[0]) begin
            gen_prbs <= prbs_next(gen_prbs);
          end
          if (gcnt == data_last) begin
            pkt_sent <= 1'b1;
            gcnt <= '0;
            if (gap_len != 8'h00) begin
              gen_state <= G_GAP;
            end else begin
              gen_state <= gen_en ? G_PRE : G_IDLE;
            end
          end
        end
        G_GAP: begin
          // Gap ends straight into the next preamble, so no extra idle cycle
          if (gcnt == gap_last) begin
            gcnt <= '0;
            gen_state <= gen_en ? G_PRE : G_IDLE;
          end
        end
      endcase
    end
  end

  // Checker: hunt for the delimiter, then compare byte by byte
  pbe_chk_t chk_state;
  logic prev_pre;
  logic half;
  logic [3:0] lo_nib;
  logic [7:0] chk_prbs;
  logic byte_inc;
  logic err_inc;
  logic pkt_inc;
  logic [7:0] rx_byte;
  assign rx_byte = {RX_NIB, lo_nib};
  assign byte_inc = (chk_state == C_DATA) & RX_DV & half;
  assign err_inc = byte_inc & (rx_byte != chk_prbs);
  assign pkt_inc = (chk_state == C_DATA) & ~RX_DV;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      chk_state <= C_HUNT;
      prev_pre <= 1'b0;
      half <= 1'b0;
      lo_nib <= '0;
      chk_prbs <= PRBS_SEED;
    end else begin
      unique case (chk_state)
        C_HUNT: begin
          prev_pre <= RX_DV & (RX_NIB == NIB_PRE);
          half <= 1'b0;
          chk_prbs <= PRBS_SEED;
          if (RX_DV && prev_pre && RX_NIB == SFD[7:4]) begin
            chk_state <= C_DATA;
          end
        end
        C_DATA: begin
          prev_pre <= 1'b0;
          // A trailing odd nibble is dropped with the frame end
          if (!RX_DV) begin
            chk_state <= C_HUNT;
          end else begin
            half <= ~half;
            lo_nib <= RX_NIB;
            if (half) begin
              chk_prbs <= prbs_next(chk_prbs);
            end
          end
        end
      endcase
    end
  end

  // Live counters: a clear beats a same-cycle increment
  logic [15:0] byte_live;
  logic [15:0] pkt_live;
  logic [7:0] err_live;
  logic byte_ovf;
  logic pkt_ovf;
  logic byte_wrap;
  logic pkt_wrap;
  assign byte_wrap = byte_inc & (byte_live == 16'hffff);
  assign pkt_wrap = pkt_inc & (pkt_live == 16'hffff);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      byte_live <= '0;
      pkt_live <= '0;
      err_live <= '0;
    end else if (clr_pulse) begin
      byte_live <= '0;
      pkt_live <= '0;
      err_live <= '0;
    end else begin
      if (byte_inc && (sat_mode || !byte_wrap)) begin
        byte_live <= byte_live + 16'd1;
      end
      if (pkt_inc && (sat_mode || !pkt_wrap)) begin
        pkt_live <= pkt_live + 16'd1;
      end
      if (err_inc && (sat_mode || err_live != 8'hff)) begin
        err_live <= err_live + 8'd1;
      end
    end
  end

  // Overflow flags: a same-cycle overflow wins over the clear
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      byte_ovf <= 1'b0;
      pkt_ovf <= 1'b0;
    end else begin
      byte_ovf <= byte_wrap | (byte_ovf & ~clr_pulse);
      pkt_ovf <= pkt_wrap | (pkt_ovf & ~clr_pulse);
    end
  end

  // Snapshot for software; reads never see a half-updated set
  logic [15:0] lk_byte;
  logic [15:0] lk_pkt;
  logic [7:0] lk_err;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lk_byte <= '0;
      lk_pkt <= '0;
      lk_err <= '0;
    end else if (lock_pulse) begin
      lk_byte <= byte_live;
      lk_pkt <= pkt_live;
      lk_err <= err_live;
    end
  end

  // Interrupts
  logic [EV_W-1:0] irq_sts;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] irq_clr;
  assign ev = {pkt_sent, pkt_wrap, byte_wrap};
  assign irq_clr = (wr_lo && idx == IDX_IRQ_CLR) ?
    AVS_WRITEDATA[EV_W-1:0] : '0;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_sts <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_sts <= ev | (irq_sts & ~irq_clr);
      IRQ <= |((ev | (irq_sts & ~irq_clr)) & irq_en);
    end
  end

  // Read data latched in the wait cycle
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    unique case (idx)
      IDX_CFG: begin
        next_rdata[BIT_SAT_MODE] = sat_mode;
        next_rdata[BIT_GEN_EN] = gen_en;
      end
      IDX_PKT_CNT: next_rdata[15:0] = lk_pkt;
      IDX_BYTE_CNT: next_rdata[15:0] = lk_byte;
      IDX_STS_LOCK: begin
        next_rdata[7:0] = lk_err;
        next_rdata[BIT_BYTE_OVF] = byte_ovf;
        next_rdata[BIT_PKT_OVF] = pkt_ovf;
      end
      IDX_PKT_LEN: next_rdata[15:0] = pkt_len;
      IDX_GAP: next_rdata[7:0] = gap_len;
      IDX_IRQ_STS: next_rdata[EV_W-1:0] = irq_sts;
      IDX_IRQ_EN: next_rdata[EV_W-1:0] = irq_en;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      AVS_READDATA <= '0;
    end else if (AVS_READ && !ack) begin
      AVS_READDATA <= next_rdata;
    end
  end

  // Checks
  property p_err_sat;
    @(posedge CLK) disable iff (SYS_RST)
    (!sat_mode && err_live == 8'hff && !clr_pulse) |=> err_live == 8'hff;
  endproperty
  a_err_sat: assert property (p_err_sat)
    else $error("error count left 0xff in saturate mode");

  property p_byte_sat;
    @(posedge CLK) disable iff (SYS_RST)
    (!sat_mode && byte_live == 16'hffff && !clr_pulse)
      |=> byte_live == 16'hffff;
  endproperty
  a_byte_sat: assert property (p_byte_sat)
    else $error("byte count left 0xffff in saturate mode");

  property p_snap;
    @(posedge CLK) disable iff (SYS_RST)
    lock_pulse |=> (lk_byte == $past(byte_live) &&
      lk_pkt == $past(pkt_live) && lk_err == $past(err_live));
  endproperty
  a_snap: assert property (p_snap)
    else $error("lock did not capture all counts together");

  property p_clear;
    @(posedge CLK) disable iff (SYS_RST)
    clr_pulse |=> (byte_live == 16'h0000 && err_live == 8'h00 &&
      pkt_live == 16'h0000) ##0 lk_err == $past(err_live);
  endproperty
  a_clear: assert property (p_clear)
    else $error("lock and clear failed");

  property p_byte_ovf;
    @(posedge CLK) disable iff (SYS_RST)
    byte_inc && byte_live == 16'hffff |=> byte_ovf;
  endproperty
  a_byte_ovf: assert property (p_byte_ovf)
    else $error("byte overflow flag not set");

  property p_pkt_ovf;
    @(posedge CLK) disable iff (SYS_RST)
    pkt_inc && pkt_live == 16'hffff |=> pkt_ovf;
  endproperty
  a_pkt_ovf: assert property (p_pkt_ovf)
    else $error("packet overflow flag not set");

  property p_ovf_hold;
    @(posedge CLK) disable iff (SYS_RST)
    (byte_ovf || pkt_ovf) && !clr_pulse
      |=> (byte_ovf || !$past(byte_ovf)) && (pkt_ovf || !$past(pkt_ovf));
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow flag dropped without clear");

  sequence s_pre;
    (TX_EN && TX_NIB == 4'h5) [*8] ##1 (TX_EN && TX_NIB == 4'h5) [*6];
  endsequence
  sequence s_sfd_hi;
    TX_EN && TX_NIB == 4'hd;
  endsequence
  property p_frame_start;
    @(posedge CLK) disable iff (SYS_RST)
    $rose(TX_EN) |-> s_pre ##1 s_sfd_hi;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("preamble or delimiter malformed");
endmodule

// ===== design/pbe_pkg.sv
// Package: register map, field layout and framing constants of the BIST engine
package pbe_pkg;
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_CFG = 8'h16;
  localparam logic [7:0] IDX_PKT_CNT = 8'h17;
  localparam logic [7:0] IDX_BYTE_CNT = 8'h71;
  localparam logic [7:0] IDX_STS_LOCK = 8'h72;
  localparam logic [7:0] IDX_PKT_LEN = 8'h7b;
  localparam logic [7:0] IDX_GAP = 8'h7c;
  localparam logic [7:0] IDX_IRQ_STS = 8'h80;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h81;
  localparam logic [7:0] IDX_IRQ_EN = 8'h82;
  localparam int BIT_LOCK = 0;
  localparam int BIT_LOCK_CLR = 1;
  localparam int BIT_BYTE_OVF = 9;
  localparam int BIT_PKT_OVF = 10;
  localparam int BIT_SAT_MODE = 0;
  localparam int BIT_GEN_EN = 1;
  localparam int EV_BYTE_OVF = 0;
  localparam int EV_PKT_OVF = 1;
  localparam int EV_PKT_SENT = 2;
  localparam int EV_W = 3;
  localparam logic [15:0] RST_PKT_LEN = 16'h05dc;
  localparam logic [7:0] RST_GAP = 8'h7d;
  localparam logic [16:0] PRE_NIBS = 17'd13;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [7:0] SFD = 8'hd5;
  localparam int GAP_NIB_SHIFT = 3;
  localparam logic [7:0] PRBS_SEED = 8'hff;
  typedef enum logic [2:0] {G_IDLE, G_PRE, G_SFD, G_DATA, G_GAP} pbe_gen_t;
  typedef enum logic {C_HUNT, C_DATA} pbe_chk_t;
endpackage

// ===== sim/tb_top.sv
// Self-checking bench for the BIST packet engine
`timescale 1ns/100ps
module tb_top;
  import pbe_pkg::*;
  logic CLK;
  logic SYS_RST;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic tx_en;
  logic [3:0] tx_nib;
  logic rx_dv;
  logic [3:0] rx_nib;
  logic irq;
  logic corrupt;
  logic tx_q;
  int nib_i;
  int n_frm;
  int n0;
  int n_fail;
  int checked;
  int cyc;

  pbe_engine u_dut (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read),
    .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest),
    .TX_EN(tx_en),
    .TX_NIB(tx_nib),
    .RX_DV(rx_dv),
    .RX_NIB(rx_nib),
    .IRQ(irq)
  );

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Loop the generator back into the checker; corruption spares framing
  always @(posedge CLK) begin
    rx_dv <= tx_en;
    rx_nib <= tx_nib ^ ((corrupt && nib_i >= 15) ? 4'h1 : 4'h0);
    nib_i <= (tx_en === 1'b1) ? nib_i + 1 : 0;
    tx_q <= tx_en;
    if (tx_q === 1'b1 && tx_en === 1'b0) begin
      n_frm <= n_frm + 1;
    end
    cyc <= cyc + 1;
  end

  task automatic wrap_up();
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Request held until waitrequest is seen low, released after that edge
  // An idle edge first, so back-to-back calls never retoggle a strobe
  task automatic av_wr(input logic [7:0] idx, input logic [31:0] d);
    @(posedge CLK);
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge CLK); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic av_rd(input logic [7:0] idx, output logic [31:0] d);
    @(posedge CLK);
    avs_address <= {idx, 2'b00};
    avs_read <= 1'b1;
    do @(posedge CLK); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] idx,
                        input logic [31:0] e);
    logic [31:0] v;
    av_rd(idx, v);
    chk(nm, e, v);
  endtask

  // Walks one frame nibble by nibble, then measures the idle gap
  task automatic tx_frame(input int len, input int gap);
    logic [7:0] s;
    logic [3:0] e;
    int g;
    s = PRBS_SEED;
    while (tx_en !== 1'b1) @(negedge CLK);
    for (int i = 0; i < 15 + 2 * len; i++) begin
      if (i < 14) e = NIB_PRE;
      else if (i == 14) e = 4'hd;
      else if (i % 2 == 1) e = s[3:0];
      else begin
        e = s[7:4];
        s = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
      end
      chk("tx nibble", {1'b1, e}, {tx_en, tx_nib});
      @(negedge CLK);
    end
    g = 0;
    while (tx_en === 1'b0 && g < 4000) begin
      g++;
      @(negedge CLK);
    end
    chk("gap cycles", 8 * gap, g);
  endtask

  task automatic t_reset();
    rd_chk("len reset", IDX_PKT_LEN, 32'h05dc);
    rd_chk("gap reset", IDX_GAP, 32'h007d);
    rd_chk("status reset", IDX_STS_LOCK, 32'h0);
    rd_chk("unmapped", 8'h00, 32'h0);
  endtask

  task automatic t_gen();
    av_wr(IDX_PKT_LEN, 32'h3);
    av_wr(IDX_GAP, 32'h1201);
    rd_chk("gap width", IDX_GAP, 32'h1);
    av_wr(IDX_CFG, 32'h2);
    tx_frame(3, 1);
    tx_frame(3, 1);
    av_wr(IDX_CFG, 32'h0);
    repeat (100) @(posedge CLK);
    av_wr(IDX_STS_LOCK, 32'h1);
    rd_chk("byte count", IDX_BYTE_CNT, 3 * n_frm);
    rd_chk("pkt count", IDX_PKT_CNT, n_frm);
    rd_chk("err count", IDX_STS_LOCK, 32'h0);
  endtask

  // Packet-sent event: raised, masked, enabled, cleared
  task automatic t_irq();
    rd_chk("irq status", IDX_IRQ_STS, 32'h4);
    @(negedge CLK);
    chk("irq masked", 1'b0, irq);
    av_wr(IDX_IRQ_EN, 32'h4);
    repeat (2) @(negedge CLK);
    chk("irq on", 1'b1, irq);
    av_wr(IDX_IRQ_CLR, 32'h4);
    repeat (2) @(negedge CLK);
    chk("irq off", 1'b0, irq);
    rd_chk("irq cleared", IDX_IRQ_STS, 32'h0);
  endtask

  task automatic t_err();
    av_wr(IDX_STS_LOCK, 32'h2);
    rd_chk("pre-clear snap", IDX_BYTE_CNT, 3 * n_frm);
    av_wr(IDX_BYTE_CNT, 32'hffff);
    av_wr(IDX_STS_LOCK, 32'h1);
    rd_chk("cleared bytes", IDX_BYTE_CNT, 32'h0);
    rd_chk("cleared pkts", IDX_PKT_CNT, 32'h0);
    rd_chk("cleared flags", IDX_STS_LOCK, 32'h0);
    n0 = n_frm;
    corrupt = 1'b1;
    av_wr(IDX_PKT_LEN, 32'h2);
    av_wr(IDX_CFG, 32'h2);
    repeat (60) @(posedge CLK);
    av_wr(IDX_CFG, 32'h0);
    repeat (100) @(posedge CLK);
    av_wr(IDX_STS_LOCK, 32'h1);
    rd_chk("err bytes", IDX_STS_LOCK, 2 * (n_frm - n0));
    rd_chk("err run bytes", IDX_BYTE_CNT, 2 * (n_frm - n0));
    rd_chk("err run pkts", IDX_PKT_CNT, n_frm - n0);
  endtask

  // Long corrupted frame pushes the error count past its ceiling
  task automatic t_sat();
    av_wr(IDX_PKT_LEN, 32'h12c);
    av_wr(IDX_CFG, 32'h2);
    while (tx_en !== 1'b1) @(negedge CLK);
    av_wr(IDX_CFG, 32'h0);
    repeat (900) @(posedge CLK);
    av_wr(IDX_STS_LOCK, 32'h1);
    rd_chk("err saturate", IDX_STS_LOCK, 32'hff);
    // Same frame in wrap mode: 300 error bytes leave 300 mod 256
    av_wr(IDX_STS_LOCK, 32'h2);
    av_wr(IDX_CFG, 32'h3);
    while (tx_en !== 1'b1) @(negedge CLK);
    av_wr(IDX_CFG, 32'h1);
    repeat (900) @(posedge CLK);
    av_wr(IDX_STS_LOCK, 32'h1);
    rd_chk("err wrap", IDX_STS_LOCK, 32'h2c);
    rd_chk("wrap bytes", IDX_BYTE_CNT, 32'h12c);
  endtask

  initial begin
    SYS_RST = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    corrupt = 1'b0;
    n_fail = 0;
    checked = 0;
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    // A hang anywhere ends at the ceiling and counts as a mismatch
    fork
      begin
        t_reset();
        t_gen();
        t_irq();
        t_err();
        t_sat();
      end
      begin
        wait (cyc >= 30000);
        n_fail++;
      end
    join_any
    wrap_up();
  end
endmodule
